// [src/cmp_pga_defs.svh]
`ifndef CMP_PGA_DEFS_SVH
`define CMP_PGA_DEFS_SVH
// register byte addresses
`define OFS_AMP_CTRL 12'h000
`define OFS_CMP0_REF 12'h004
`define OFS_CMP1_REF 12'h008
`define OFS_REF_ROUTE 12'h00C
`define OFS_FILT_EDGE 12'h010
`define OFS_OUT_CTRL 12'h014
`define OFS_PRIO_UL 12'h018
`define OFS_PRIO_LL 12'h01C
`define OFS_PRIO_UH 12'h020
`define OFS_PRIO_LH 12'h024
`define OFS_MODE 12'h028
`define OFS_STATUS 12'h02C
// reset values
`define RST_AMP_CTRL 8'h01
`define RST_CMP0_REF 8'h00
`define RST_CMP1_REF 8'h66
`define RST_REF_ROUTE 8'h00
`define RST_FILT_EDGE 8'h00
`define RST_OUT_CTRL 8'h00
`define RST_PRIO 8'hFF
`define RST_MODE 8'h00
// field positions
`define BIT_AMP_RUN 7
`define BIT_CMP1_SEL 6
`define BIT_REF1_RUN 5
`define BIT_GND_SEL 4
`define BIT_CMP0_SEL 2
`define BIT_REF0_RUN 1
`define BIT_SUP_SEL 0
`define BIT_C1_EDGE 7
`define BIT_C1_POL 6
`define BIT_C0_EDGE 3
`define BIT_C0_POL 2
`define BIT_C1_INV 6
`define BIT_C1_GATE 5
`define BIT_C1_IRQ 4
`define BIT_C0_INV 2
`define BIT_C0_GATE 1
`define BIT_C0_IRQ 0
`define BIT_C1_RUN 4
`define BIT_C0_RUN 0
// timing counts, in peripheral clocks
`define DIV_SLOW 8
`define DIV_SLOWER 32
`endif

// [src/cmp_pga_pkg.sv]
package cmp_pga_pkg;
   typedef enum logic [1:0] {
      GAIN_X4 = 2'h0,
      GAIN_X8 = 2'h1,
      GAIN_X16 = 2'h2,
      GAIN_X32 = 2'h3
   } gain_type;
   typedef enum logic [1:0] {
      FILT_NONE = 2'h0,
      FILT_CLK = 2'h1,
      FILT_DIV8 = 2'h2,
      FILT_DIV32 = 2'h3
   } filter_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SETUP = 3'b010,
      ST_ACCESS = 3'b100
   } bus_state_type;
endpackage : cmp_pga_pkg

// [src/cmp_sample_filter.sv]
`include "cmp_pga_defs.svh"
// with a filter rate chosen, three matching samples at that rate pass a level through; with none the raw level passes
module cmp_sample_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic raw,
   input wire cmp_pga_pkg::filter_type sel,
   input wire logic tick_clk,
   input wire logic tick_div8,
   input wire logic tick_div32,
   output logic level
);
   logic [2:0] hist_q;
   logic tick;
   always_comb begin
      case (sel)
         cmp_pga_pkg::FILT_CLK: tick = tick_clk;
         cmp_pga_pkg::FILT_DIV8: tick = tick_div8;
         cmp_pga_pkg::FILT_DIV32: tick = tick_div32;
         default: tick = 1'b1;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_q <= 3'h0;
      end else if (!run) begin
         hist_q <= 3'h0;
      end else if (tick) begin
         hist_q <= {hist_q[1:0], raw};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b0;
      end else if (!run) begin
         level <= 1'b0;
      end else if (sel == cmp_pga_pkg::FILT_NONE) begin
         level <= raw;
      end else if (hist_q == 3'h7) begin
         level <= 1'b1;
      end else if (hist_q == 3'h0) begin
         level <= 1'b0;
      end
   end
endmodule : cmp_sample_filter

// [src/cmp_edge_detect.sv]
// one-cycle request on the selected edge(s) of a filtered level
module cmp_edge_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level,
   input wire logic both_edges,
   input wire logic falling,
   output logic pulse
);
   logic prev_q;
   logic rise;
   logic fall;
   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end
   always_comb begin
      if (both_edges) begin
         pulse = rise | fall;
      end else if (falling) begin
         pulse = fall;
      end else begin
         pulse = rise;
      end
   end
endmodule : cmp_edge_detect

// [src/comparator_pga_control.sv]
// Notes on behaviour
// - amplifier run bit and 2-bit gain: x4, x8, x16, x32
// - comparator 0 reference code n gives supply/256 times n
// - comparator 1 own 8-bit reference code, same scaling
// - routing bit 6: comparator 1 input pin or amplifier output
// - routing bit 2: comparator 0 input pin or amplifier output
// - bits 5 and 1 run reference generators 1 and 0
// - bit 4 selects ordinary ground or negative reference pin
// - bit 0 selects core supply or positive reference pin
// - comparator 1 edge mode: one edge or both edges
// - comparator 1 polarity: rising or falling edge request
// - comparator 1 filter: none, clock, clock/8, clock/32
// - comparator 0 edge mode and polarity, same meaning
// - comparator 0 filter: none, clock, clock/8, clock/32
// - comparator 1 output polarity: pass or invert
// - comparator 1 cutoff held low unless output enabled
// - comparator 1 interrupt requests blocked unless enabled
// - comparator 0 output polarity: pass or invert
// - comparator 0 cutoff held low unless output enabled
// - comparator 0 interrupt requests blocked unless enabled
// - comparator 0 priority from bit 7 of both low priority bytes
// - comparator 1 priority from bit 0 of both high priority bytes
// - each comparator has its own operation enable bit
`include "cmp_pga_defs.svh"
module comparator_pga_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp0_raw,
   input wire logic cmp1_raw,
   output logic amp_run,
   output logic [1:0] amp_gain,
   output logic [7:0] cmp0_ref_code,
   output logic [7:0] cmp1_ref_code,
   output logic cmp0_input_select,
   output logic cmp1_input_select,
   output logic ref0_run,
   output logic ref1_run,
   output logic ref_ground_select,
   output logic ref_supply_select,
   output logic cmp0_run,
   output logic cmp1_run,
   output logic cutoff_signal_zero,
   output logic cutoff_signal_one,
   output logic cmp0_irq,
   output logic cmp1_irq,
   output logic [1:0] cmp0_prio,
   output logic [1:0] cmp1_prio
);
   logic [7:0] amp_q;
   logic [7:0] ref0_q;
   logic [7:0] ref1_q;
   logic [7:0] route_q;
   logic [7:0] fir_q;
   logic [7:0] ocr_q;
   logic [7:0] pr_ul_q;
   logic [7:0] pr_ll_q;
   logic [7:0] pr_uh_q;
   logic [7:0] pr_lh_q;
   logic [7:0] mode_q;
   logic [4:0] div_q;
   logic tick8;
   logic tick32;
   logic lvl0;
   logic lvl1;
   logic edge0;
   logic edge1;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [7:0] rd_d;

   // 8-bit register write honouring byte lane 0
   function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] wd,
                                          input logic lane);
      wr_byte = lane ? wd[7:0] : old;
   endfunction : wr_byte

   // apb: zero wait states, access phase completes at once
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;

   always_comb begin
      hit = 1'b1;
      case (paddr)
         `OFS_AMP_CTRL: rd_d = amp_q;
         `OFS_CMP0_REF: rd_d = ref0_q;
         `OFS_CMP1_REF: rd_d = ref1_q;
         `OFS_REF_ROUTE: rd_d = route_q;
         `OFS_FILT_EDGE: rd_d = fir_q;
         `OFS_OUT_CTRL: rd_d = ocr_q;
         `OFS_PRIO_UL: rd_d = pr_ul_q;
         `OFS_PRIO_LL: rd_d = pr_ll_q;
         `OFS_PRIO_UH: rd_d = pr_uh_q;
         `OFS_PRIO_LH: rd_d = pr_lh_q;
         `OFS_MODE: rd_d = mode_q;
         `OFS_STATUS: rd_d = {6'h00, lvl1, lvl0};
         default: begin
            rd_d = 8'h00;
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         prdata <= {24'h000000, rd_d};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         amp_q <= `RST_AMP_CTRL;
         ref0_q <= `RST_CMP0_REF;
         ref1_q <= `RST_CMP1_REF;
         route_q <= `RST_REF_ROUTE;
         fir_q <= `RST_FILT_EDGE;
         ocr_q <= `RST_OUT_CTRL;
         pr_ul_q <= `RST_PRIO;
         pr_ll_q <= `RST_PRIO;
         pr_uh_q <= `RST_PRIO;
         pr_lh_q <= `RST_PRIO;
         mode_q <= `RST_MODE;
      end else if (wr_en) begin
         case (paddr)
            `OFS_AMP_CTRL: amp_q <= wr_byte(amp_q, pwdata, pstrb[0]) & 8'h83;
            `OFS_CMP0_REF: ref0_q <= wr_byte(ref0_q, pwdata, pstrb[0]);
            `OFS_CMP1_REF: ref1_q <= wr_byte(ref1_q, pwdata, pstrb[0]);
            `OFS_REF_ROUTE: route_q <= wr_byte(route_q, pwdata, pstrb[0]) & 8'h77;
            `OFS_FILT_EDGE: fir_q <= wr_byte(fir_q, pwdata, pstrb[0]);
            `OFS_OUT_CTRL: ocr_q <= wr_byte(ocr_q, pwdata, pstrb[0]) & 8'h77;
            `OFS_PRIO_UL: pr_ul_q <= wr_byte(pr_ul_q, pwdata, pstrb[0]);
            `OFS_PRIO_LL: pr_ll_q <= wr_byte(pr_ll_q, pwdata, pstrb[0]);
            `OFS_PRIO_UH: pr_uh_q <= wr_byte(pr_uh_q, pwdata, pstrb[0]);
            `OFS_PRIO_LH: pr_lh_q <= wr_byte(pr_lh_q, pwdata, pstrb[0]);
            `OFS_MODE: mode_q <= wr_byte(mode_q, pwdata, pstrb[0]) & 8'h11;
            default: ;
         endcase
      end
   end

   // static control outputs, registered copies of fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         amp_run <= 1'b0;
         amp_gain <= 2'h1;
         cmp0_ref_code <= `RST_CMP0_REF;
         cmp1_ref_code <= `RST_CMP1_REF;
         cmp0_input_select <= 1'b0;
         cmp1_input_select <= 1'b0;
         ref0_run <= 1'b0;
         ref1_run <= 1'b0;
         ref_ground_select <= 1'b0;
         ref_supply_select <= 1'b0;
         cmp0_run <= 1'b0;
         cmp1_run <= 1'b0;
         cmp0_prio <= 2'h3;
         cmp1_prio <= 2'h3;
      end else begin
         amp_run <= amp_q[`BIT_AMP_RUN];
         amp_gain <= amp_q[1:0];
         cmp0_ref_code <= ref0_q;
         cmp1_ref_code <= ref1_q;
         cmp1_input_select <= route_q[`BIT_CMP1_SEL];
         cmp0_input_select <= route_q[`BIT_CMP0_SEL];
         ref1_run <= route_q[`BIT_REF1_RUN];
         ref0_run <= route_q[`BIT_REF0_RUN];
         ref_ground_select <= route_q[`BIT_GND_SEL];
         ref_supply_select <= route_q[`BIT_SUP_SEL];
         cmp1_run <= mode_q[`BIT_C1_RUN];
         cmp0_run <= mode_q[`BIT_C0_RUN];
         cmp0_prio <= {pr_ul_q[7], pr_ll_q[7]};
         cmp1_prio <= {pr_uh_q[0], pr_lh_q[0]};
      end
   end

   // sampling rate divider, /8 and /32 pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end
   assign tick8 = (div_q[2:0] == 3'(`DIV_SLOW - 1));
   assign tick32 = (div_q == 5'(`DIV_SLOWER - 1));

   cmp_sample_filter u_filt0 (
      .pclk(pclk),
      .presetn(presetn),
      .run(mode_q[`BIT_C0_RUN]),
      .raw(cmp0_raw),
      .sel(cmp_pga_pkg::filter_type'(fir_q[1:0])),
      .tick_clk(1'b1),
      .tick_div8(tick8),
      .tick_div32(tick32),
      .level(lvl0)
   );
   cmp_sample_filter u_filt1 (
      .pclk(pclk),
      .presetn(presetn),
      .run(mode_q[`BIT_C1_RUN]),
      .raw(cmp1_raw),
      .sel(cmp_pga_pkg::filter_type'(fir_q[5:4])),
      .tick_clk(1'b1),
      .tick_div8(tick8),
      .tick_div32(tick32),
      .level(lvl1)
   );
   // edges taken from filtered levels
   cmp_edge_detect u_edge0 (
      .pclk(pclk),
      .presetn(presetn),
      .level(lvl0),
      .both_edges(fir_q[`BIT_C0_EDGE]),
      .falling(fir_q[`BIT_C0_POL]),
      .pulse(edge0)
   );
   cmp_edge_detect u_edge1 (
      .pclk(pclk),
      .presetn(presetn),
      .level(lvl1),
      .both_edges(fir_q[`BIT_C1_EDGE]),
      .falling(fir_q[`BIT_C1_POL]),
      .pulse(edge1)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp0_irq <= 1'b0;
         cmp1_irq <= 1'b0;
      end else begin
         cmp0_irq <= edge0 & ocr_q[`BIT_C0_IRQ];
         cmp1_irq <= edge1 & ocr_q[`BIT_C1_IRQ];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cutoff_signal_zero <= 1'b0;
         cutoff_signal_one <= 1'b0;
      end else begin
         cutoff_signal_zero <= ocr_q[`BIT_C0_GATE] & (lvl0 ^ ocr_q[`BIT_C0_INV]);
         cutoff_signal_one <= ocr_q[`BIT_C1_GATE] & (lvl1 ^ ocr_q[`BIT_C1_INV]);
      end
   end

   a_cutoff_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(ocr_q[`BIT_C1_GATE]) |-> !cutoff_signal_one)
      else $error("cutoff one not held low");
   a_cutoff0_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(ocr_q[`BIT_C0_GATE]) |-> !cutoff_signal_zero)
      else $error("cutoff zero not held low");
   a_irq1_block: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(ocr_q[`BIT_C1_IRQ]) |-> !cmp1_irq)
      else $error("cmp1 request while blocked");
   a_irq0_block: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(ocr_q[`BIT_C0_IRQ]) |-> !cmp0_irq)
      else $error("cmp0 request while blocked");
   a_irq1_rise: assert property (@(posedge pclk) disable iff (!presetn)
      cmp1_irq && !$past(fir_q[`BIT_C1_EDGE]) && !$past(fir_q[`BIT_C1_POL])
      |-> $past(lvl1) && !$past(lvl1, 2))
      else $error("cmp1 request not on rising edge");
   a_irq0_edge: assert property (@(posedge pclk) disable iff (!presetn)
      cmp0_irq |-> $past(lvl0) != $past(lvl0, 2))
      else $error("cmp0 request without edge");
   a_prio_map: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 cmp0_prio == {$past(pr_ul_q[7]), $past(pr_ll_q[7])})
      else $error("cmp0 priority mismatch");
   a_prio1_map: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 cmp1_prio == {$past(pr_uh_q[0]), $past(pr_lh_q[0])})
      else $error("cmp1 priority mismatch");
   a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_q[`BIT_C1_RUN] [*3] |=> !lvl1)
      else $error("stopped comparator 1 shows level");
   a_gain_follow: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_AMP_CTRL && pstrb[0] |-> ##2 amp_gain == $past(pwdata[1:0], 2))
      else $error("gain not applied");
   a_run_follow: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_AMP_CTRL && pstrb[0] |-> ##2 amp_run == $past(pwdata[7], 2))
      else $error("run bit not applied");
   a_ref0_follow: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_CMP0_REF && pstrb[0]
      |-> ##2 cmp0_ref_code == $past(pwdata[7:0], 2))
      else $error("cmp0 reference code not applied");
   a_ref1_follow: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_CMP1_REF && pstrb[0]
      |-> ##2 cmp1_ref_code == $past(pwdata[7:0], 2))
      else $error("cmp1 reference code not applied");
   a_route_follow: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_REF_ROUTE && pstrb[0] |-> ##2
      {cmp1_input_select, ref1_run, ref_ground_select} == $past(pwdata[6:4], 2) &&
      {cmp0_input_select, ref0_run, ref_supply_select} == $past(pwdata[2:0], 2))
      else $error("routing fields not applied");
   a_mode_follow: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_MODE && pstrb[0]
      |-> ##2 cmp1_run == $past(pwdata[4], 2) && cmp0_run == $past(pwdata[0], 2))
      else $error("run enables not applied");
   a_cut1_pol: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ocr_q[`BIT_C1_GATE])
      |-> cutoff_signal_one == ($past(lvl1) ^ $past(ocr_q[`BIT_C1_INV])))
      else $error("cutoff one polarity wrong");
   a_cut0_pol: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ocr_q[`BIT_C0_GATE])
      |-> cutoff_signal_zero == ($past(lvl0) ^ $past(ocr_q[`BIT_C0_INV])))
      else $error("cutoff zero polarity wrong");
   a_irq1_both: assert property (@(posedge pclk) disable iff (!presetn)
      cmp1_irq && $past(fir_q[`BIT_C1_EDGE]) |-> $past(lvl1) != $past(lvl1, 2))
      else $error("cmp1 request without edge");
   a_irq1_fall: assert property (@(posedge pclk) disable iff (!presetn)
      cmp1_irq && !$past(fir_q[`BIT_C1_EDGE]) && $past(fir_q[`BIT_C1_POL])
      |-> !$past(lvl1) && $past(lvl1, 2))
      else $error("cmp1 request not on falling edge");
   a_irq0_fall: assert property (@(posedge pclk) disable iff (!presetn)
      cmp0_irq && !$past(fir_q[`BIT_C0_EDGE]) && $past(fir_q[`BIT_C0_POL])
      |-> !$past(lvl0) && $past(lvl0, 2))
      else $error("cmp0 request not on falling edge");
   a_irq1_pass: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ocr_q[`BIT_C1_IRQ]) && $past(fir_q[`BIT_C1_EDGE])
      && $past(lvl1) != $past(lvl1, 2) |-> cmp1_irq)
      else $error("cmp1 request lost");
   a_irq0_pass: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ocr_q[`BIT_C0_IRQ]) && $past(fir_q[`BIT_C0_EDGE])
      && $past(lvl0) != $past(lvl0, 2) |-> cmp0_irq)
      else $error("cmp0 request lost");
   a_off0_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_q[`BIT_C0_RUN] |=> !lvl0)
      else $error("stopped comparator 0 shows level");
   a_div8_period: assert property (@(posedge pclk) disable iff (!presetn)
      tick8 |=> !tick8 [*7] ##1 tick8)
      else $error("divide by 8 pulse spacing wrong");
   a_div32_period: assert property (@(posedge pclk) disable iff (!presetn)
      tick32 |-> tick8 ##32 tick32)
      else $error("divide by 32 pulse spacing wrong");
   a_filt1_none: assert property (@(posedge pclk) disable iff (!presetn)
      $past(fir_q[5:4]) == 2'h0 && $past(mode_q[`BIT_C1_RUN]) |-> lvl1 == $past(cmp1_raw))
      else $error("unfiltered cmp1 level wrong");
   a_filt0_none: assert property (@(posedge pclk) disable iff (!presetn)
      $past(fir_q[1:0]) == 2'h0 && $past(mode_q[`BIT_C0_RUN]) |-> lvl0 == $past(cmp0_raw))
      else $error("unfiltered cmp0 level wrong");
endmodule : comparator_pga_control

// [verif/analog_front_model.sv]
// comparators and gain stage as seen by the control block
module analog_front_model (
   input wire logic pclk,
   input wire logic [7:0] pin0,
   input wire logic [7:0] pin1,
   input wire logic [7:0] sense,
   input wire logic amp_run,
   input wire logic [1:0] amp_gain,
   input wire logic [7:0] ref0,
   input wire logic [7:0] ref1,
   input wire logic sel0,
   input wire logic sel1,
   input wire logic ref0_run,
   input wire logic ref1_run,
   output logic raw0,
   output logic raw1
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] amp_out;
   // gain is 4 shifted left by the code
   assign amp_out = amp_run ? ({8'h00, sense} << ({1'b0, amp_gain} + 3'h2)) : 16'h0000;
   // stopped reference means no trip
   always_ff @(posedge pclk) begin
      raw0 <= ref0_run & ((sel0 ? amp_out : {8'h00, pin0}) > {8'h00, ref0});
      raw1 <= ref1_run & ((sel1 ? amp_out : {8'h00, pin1}) > {8'h00, ref1});
   end
endmodule : analog_front_model

// [verif/tb_top.sv]
`include "cmp_pga_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic cmp0_raw, cmp1_raw, amp_run, cmp0_input_select, cmp1_input_select;
   logic ref0_run, ref1_run, ref_ground_select, ref_supply_select, cmp0_run, cmp1_run;
   logic cutoff_signal_zero, cutoff_signal_one, cmp0_irq, cmp1_irq;
   logic [1:0] amp_gain, cmp0_prio, cmp1_prio;
   logic [7:0] cmp0_ref_code, cmp1_ref_code, pin0, pin1, sense, v;
   int n_mismatch, n_compared, seed, irq0_n, irq1_n, b0, b1;

   comparator_pga_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .cmp0_raw, .cmp1_raw, .amp_run,
      .amp_gain, .cmp0_ref_code, .cmp1_ref_code, .cmp0_input_select,
      .cmp1_input_select, .ref0_run, .ref1_run, .ref_ground_select,
      .ref_supply_select, .cmp0_run, .cmp1_run, .cutoff_signal_zero,
      .cutoff_signal_one, .cmp0_irq, .cmp1_irq, .cmp0_prio, .cmp1_prio);
   analog_front_model u_front (.pclk, .pin0, .pin1, .sense, .amp_run, .amp_gain,
      .ref0(cmp0_ref_code), .ref1(cmp1_ref_code), .sel0(cmp0_input_select),
      .sel1(cmp1_input_select), .ref0_run, .ref1_run, .raw0(cmp0_raw), .raw1(cmp1_raw));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (cmp0_irq === 1'b1) irq0_n <= irq0_n + 1;
      if (cmp1_irq === 1'b1) irq1_n <= irq1_n + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim

   // one transfer; ends at the edge where pready was seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, 4'hF);
      chk(rd, {24'h000000, e});
   endtask : rchk

   // status bits expected when both comparators watch the amplifier against code 80
   function automatic logic [7:0] trip(input logic run, input logic [1:0] g,
                                       input logic [7:0] s);
      trip = (run && 16'(s) * (16'h0004 << g) > 16'h0080) ? 8'h03 : 8'h00;
   endfunction : trip

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick

   task automatic pins(input logic [7:0] x);
      @(posedge pclk);
      pin0 <= x;
      pin1 <= x;
   endtask : pins

   initial begin
      #2_000_000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      seed = 32'h1C4F;
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {pin0, pin1, sense} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      chk({amp_gain, cmp1_ref_code, cmp0_prio, cmp1_prio}, {2'h1, 8'h66, 4'hF});
      rchk(`OFS_AMP_CTRL, 8'h01);
      rchk(`OFS_CMP1_REF, 8'h66);
      rchk(`OFS_PRIO_LH, 8'hFF);
      rchk(`OFS_MODE, 8'h00);
      apb(1'b0, 12'h030, 8'h00, 4'hF);
      chk(rd, 32'h00000000);
      chk({31'h00000000, err}, 32'h00000001);
      $display("test reset_and_unmapped done");
      for (int i = 0; i < 16; i++) begin
         v = 8'($random(seed));
         apb(1'b1, `OFS_AMP_CTRL, v & 8'h83, 4'hF);
         apb(1'b1, `OFS_CMP0_REF, v, 4'hF);
         apb(1'b1, `OFS_CMP1_REF, ~v, 4'hF);
         apb(1'b1, `OFS_REF_ROUTE, v & 8'h77, 4'hF);
         apb(1'b1, `OFS_PRIO_UL, v, 4'hF);
         apb(1'b1, `OFS_PRIO_LL, {v[6:0], v[7]}, 4'hF);
         apb(1'b1, `OFS_PRIO_UH, v, 4'hF);
         apb(1'b1, `OFS_PRIO_LH, {v[0], v[7:1]}, 4'hF);
         tick(1);
         chk({amp_run, amp_gain}, {v[7], v[1:0]});
         chk({cmp0_ref_code, cmp1_ref_code}, {v, ~v});
         chk({cmp1_input_select, ref1_run, ref_ground_select}, v[6:4]);
         chk({cmp0_input_select, ref0_run, ref_supply_select}, v[2:0]);
         chk({cmp0_prio, cmp1_prio}, {v[7:6], v[0], v[1]});
         rchk(`OFS_AMP_CTRL, v & 8'h83);
      end
      apb(1'b1, `OFS_CMP0_REF, ~v, 4'hE);
      rchk(`OFS_CMP0_REF, v);
      $display("test register_fields done");
      apb(1'b1, `OFS_CMP0_REF, 8'h80, 4'hF);
      apb(1'b1, `OFS_CMP1_REF, 8'h80, 4'hF);
      apb(1'b1, `OFS_REF_ROUTE, 8'h22, 4'hF);
      apb(1'b1, `OFS_MODE, 8'h11, 4'hF);
      // c: edge mode, polarity, irq allow, invert, gate
      for (int c = 0; c < 32; c++) begin
         apb(1'b1, `OFS_FILT_EDGE, {c[0], c[1], 2'h0, c[0], c[1], 2'h0}, 4'hF);
         apb(1'b1, `OFS_OUT_CTRL, {1'b0, c[3], c[4], c[2], 1'b0, c[3], c[4], c[2]}, 4'hF);
         b0 = irq0_n;
         b1 = irq1_n;
         pins(8'hFF);
         tick(10);
         chk({cutoff_signal_one, cutoff_signal_zero}, {2{c[4] & ~c[3]}});
         rchk(`OFS_STATUS, 8'h03);
         pins(8'h00);
         tick(10);
         chk({cutoff_signal_one, cutoff_signal_zero}, {2{c[4] & c[3]}});
         chk((irq0_n - b0) * 16 + irq1_n - b1, c[2] ? (c[0] ? 34 : 17) : 0);
      end
      $display("test edges_and_outputs done");
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, `OFS_FILT_EDGE, {2'h0, f[1:0], 2'h0, f[1:0]}, 4'hF);
         apb(1'b1, `OFS_OUT_CTRL, 8'h33, 4'hF);
         b0 = irq0_n;
         b1 = irq1_n;
         pins(8'hFF);
         pins(8'h00);
         tick(150);
         chk((irq0_n - b0) * 16 + irq1_n - b1, (f == 0) ? 17 : 0);
         pins(8'hFF);
         tick(40);
         rchk(`OFS_STATUS, (f < 3) ? 8'h03 : 8'h00);
         tick(120);
         chk({cutoff_signal_one, cutoff_signal_zero}, 2'h3);
         chk((irq0_n - b0) * 16 + irq1_n - b1, (f == 0) ? 34 : 17);
         pins(8'h00);
         tick(150);
      end
      apb(1'b1, `OFS_FILT_EDGE, 8'h00, 4'hF);
      apb(1'b1, `OFS_REF_ROUTE, 8'h66, 4'hF);
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         apb(1'b1, `OFS_AMP_CTRL, {i != 0, 5'h00, v[1:0]}, 4'hF);
         @(posedge pclk);
         sense <= (i == 1) ? 8'h04 : 8'($random(seed));
         tick(10);
         rchk(`OFS_STATUS, trip(i != 0, v[1:0], sense));
      end
      apb(1'b1, `OFS_REF_ROUTE, 8'h22, 4'hF);
      $display("test amplifier_path done");
      apb(1'b1, `OFS_MODE, 8'h10, 4'hF);
      pins(8'hFF);
      tick(10);
      chk({cmp1_run, cmp0_run}, 2'h2);
      rchk(`OFS_STATUS, 8'h02);
      $display("test filters_and_enable done");
      end_sim();
   end
endmodule : tb_top
